// ### hw/cfsq_pkg.sv
// Constants and types for the configuration sequencer
// Assumes a 40 MHz mclk and an outside test-port controller
// How it works
// - erase, then load, then start-up phases
// - start on power-up; restart on request
// - memory-clear pin rises when erase ends
// - done pin high when configuration complete
// - drive memory-clear pin low during erase
// - held-low memory-clear pin blocks data loading
// - release tristate one step after done
// - next step releases flop init, write enable
// - load instruction packs TDI into words
// - test-port loading works in every mode
// - modes 101 and 001 select test port
package cfsq_pkg;
    // Datapath, memory and buffer shape
    localparam int DAT_W = 32;
    localparam int MEM_AW = 6;
    localparam int MEM_DEPTH = 64;
    localparam int BUF_DEPTH = 2;
    localparam int IR_W = 5;
    // Instruction codes of the test port
    localparam logic [4:0] IR_CFG_LOAD = 5'h05;
    localparam logic [4:0] IR_STARTUP = 5'h0C;
    localparam logic [4:0] IR_BYPASS = 5'h1F;
    localparam logic [4:0] IR_CAPTURE = 5'h01;
    // Mode pin patterns that pick the test port
    localparam logic [2:0] MODE_TAP_A = 3'h5;
    localparam logic [2:0] MODE_TAP_B = 3'h1;
    // Timing: config clock period and its half in mclk cycles
    localparam int CLK_PERIOD_NS = 25;
    localparam int CFG_CLK_PERIOD_NS = 1000;
    localparam int CFG_HALF_CYC = CFG_CLK_PERIOD_NS / (2 * CLK_PERIOD_NS);
    // Register byte offsets
    localparam logic [3:0] REG_CTRL = 4'h0;
    localparam logic [3:0] REG_STATUS = 4'h4;
    localparam logic [3:0] REG_WORDS = 4'h8;
    localparam logic [3:0] REG_MEM = 4'hC;
    // Control and status field positions and control reset value
    localparam int CTRL_RESTART_BIT = 0;
    localparam int CTRL_CFGCLK_SEL_BIT = 1;
    localparam int CTRL_IDX_LSB = 8;
    localparam int STAT_OVF_BIT = 9;
    localparam logic [6:0] CTRL_RESET = 7'h00;
    // Sequencer phases
    typedef enum logic [2:0] {
        PH_ERASE = 3'h0, PH_HOLD = 3'h1, PH_LOAD = 3'h2,
        PH_SU_DONE = 3'h3, PH_SU_TRI = 3'h4, PH_RUN = 3'h5
    } cfsq_phase_e;
    // Test-port controller states
    typedef enum logic [3:0] {
        TS_RESET = 4'h0, TS_IDLE = 4'h1, TS_SEL_DR = 4'h2, TS_CAP_DR = 4'h3,
        TS_SH_DR = 4'h4, TS_EX1_DR = 4'h5, TS_PAU_DR = 4'h6, TS_EX2_DR = 4'h7,
        TS_UPD_DR = 4'h8, TS_SEL_IR = 4'h9, TS_CAP_IR = 4'hA, TS_SH_IR = 4'hB,
        TS_EX1_IR = 4'hC, TS_PAU_IR = 4'hD, TS_EX2_IR = 4'hE, TS_UPD_IR = 4'hF
    } cfsq_tap_e;
    // Outside pins that pass the synchronisers, as one vector
    typedef struct packed {
        logic tck;
        logic tms;
        logic tdi;
        logic init;
        logic restart_n;
        logic [2:0] mode;
    } cfsq_pins_s;
    // Status register layout
    typedef struct packed {
        logic [18:0] zero;
        logic wren;
        logic finit;
        logic otri;
        logic ovf;
        logic [2:0] mode;
        logic tap_mode;
        logic init_lvl;
        logic done;
        logic [2:0] phase;
    } cfsq_status_s;
endpackage : cfsq_pkg

// ### hw/cfsq_top.sv
// Configuration sequencer: erase, test-port load, start-up release
// Assumes Avalon-MM master on mclk, test-port pins async to mclk
//
// Implementation choices: register access over Avalon-MM and the register offsets.
`timescale 1ns/1ps
`default_nettype none
module cfsq_top (
    input wire logic mclk,
    input wire logic resetn,
    input wire logic [3:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    input wire logic tck,
    input wire logic tms,
    input wire logic tdi,
    output logic tdo,
    input wire logic [2:0] mode_select_pins,
    input wire logic restart_req_n,
    input wire logic mem_clear_in,
    output logic mem_clear_out,
    output logic mem_clear_oe,
    output logic config_done,
    output logic config_clock,
    output logic global_output_tristate,
    output logic global_flop_init,
    output logic global_storage_write_enable
);
    import cfsq_pkg::*;

    ////////////////////////////////////////////////////////////////////////
    // Pin synchronisers: three flops, change taken when 2nd and 3rd agree
    localparam int SW = $bits(cfsq_pins_s);
    cfsq_pins_s raw; // Pins as one vector
    logic [SW-1:0] s1_ff, s2_ff, s3_ff, flt_ff, nxt_flt;
    cfsq_pins_s pins; // Filtered pin levels
    logic tck_prev_ff; // Last filtered test clock
    logic tck_rise, tck_fall;

    assign raw = '{tck: tck, tms: tms, tdi: tdi, init: mem_clear_in,
                   restart_n: restart_req_n, mode: mode_select_pins};
    genvar gi;
    generate
        for (gi = 0; gi < SW; gi++) begin : g_sync
            // Accept a new level only once two stages agree
            assign nxt_flt[gi] = (s2_ff[gi] == s3_ff[gi]) ? s3_ff[gi] : flt_ff[gi];
        end
    endgenerate

    // Synchroniser registers
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            s1_ff <= '0;
            s2_ff <= '0;
            s3_ff <= '0;
            flt_ff <= '0;
            tck_prev_ff <= 1'b0;
        end else begin
            s1_ff <= raw;
            s2_ff <= s1_ff;
            s3_ff <= s2_ff;
            flt_ff <= nxt_flt;
            tck_prev_ff <= pins.tck;
        end
    end
    assign pins = cfsq_pins_s'(flt_ff);
    assign tck_rise = pins.tck & ~tck_prev_ff;
    assign tck_fall = ~pins.tck & tck_prev_ff;

    ////////////////////////////////////////////////////////////////////////
    // Test-port controller and data shifting
    cfsq_tap_e tap_ff, nxt_tap;
    logic [IR_W-1:0] ir_ff, nxt_ir, irs_ff, nxt_irs;
    logic [DAT_W-1:0] dr_ff, nxt_dr; // Load shift register
    logic [4:0] bcnt_ff, nxt_bcnt; // Bits in current word
    logic byp_ff, nxt_byp, tdo_ff, nxt_tdo;
    logic push; // Word complete
    logic tap_step; // Start-up clock edge from test port

    // Standard test-port state walk
    function automatic cfsq_tap_e tap_next(input cfsq_tap_e st, input logic m);
        case (st)
            TS_RESET: tap_next = m ? TS_RESET : TS_IDLE;
            TS_IDLE, TS_UPD_DR, TS_UPD_IR: tap_next = m ? TS_SEL_DR : TS_IDLE;
            TS_SEL_DR: tap_next = m ? TS_SEL_IR : TS_CAP_DR;
            TS_CAP_DR, TS_SH_DR: tap_next = m ? TS_EX1_DR : TS_SH_DR;
            TS_EX1_DR: tap_next = m ? TS_UPD_DR : TS_PAU_DR;
            TS_PAU_DR: tap_next = m ? TS_EX2_DR : TS_PAU_DR;
            TS_EX2_DR: tap_next = m ? TS_UPD_DR : TS_SH_DR;
            TS_SEL_IR: tap_next = m ? TS_RESET : TS_CAP_IR;
            TS_CAP_IR, TS_SH_IR: tap_next = m ? TS_EX1_IR : TS_SH_IR;
            TS_EX1_IR: tap_next = m ? TS_UPD_IR : TS_PAU_IR;
            TS_PAU_IR: tap_next = m ? TS_EX2_IR : TS_PAU_IR;
            TS_EX2_IR: tap_next = m ? TS_UPD_IR : TS_SH_IR;
            default: tap_next = TS_RESET;
        endcase
    endfunction : tap_next

    // Next TAP state, shifts and TDO; runs in every mode
    always_comb begin
        nxt_tap = tap_ff;
        nxt_ir = ir_ff;
        nxt_irs = irs_ff;
        nxt_dr = dr_ff;
        nxt_bcnt = bcnt_ff;
        nxt_byp = byp_ff;
        nxt_tdo = tdo_ff;
        push = 1'b0;
        if (tck_rise) begin
            nxt_tap = tap_next(tap_ff, pins.tms);
            case (tap_ff)
                TS_CAP_IR: nxt_irs = IR_CAPTURE;
                TS_SH_IR: nxt_irs = {pins.tdi, irs_ff[IR_W-1:1]};
                TS_CAP_DR: begin
                    nxt_bcnt = 5'h00;
                    nxt_byp = 1'b0;
                end
                TS_SH_DR: begin
                    nxt_byp = pins.tdi;
                    // Pack serial data LSB first into words
                    if (ir_ff == IR_CFG_LOAD) begin
                        nxt_dr = {pins.tdi, dr_ff[DAT_W-1:1]};
                        nxt_bcnt = 5'(bcnt_ff + 5'h01);
                        push = (bcnt_ff == 5'h1F);
                    end
                end
                default: ;
            endcase
        end else if (tck_fall) begin
            // Instruction takes effect on the falling edge of update
            if (tap_ff == TS_UPD_IR) begin
                nxt_ir = irs_ff;
            end else if (tap_ff == TS_RESET) begin
                nxt_ir = IR_BYPASS;
            end
            // TDO changes on falling edge
            if (tap_ff == TS_SH_IR) begin
                nxt_tdo = irs_ff[0];
            end else if (tap_ff == TS_SH_DR && ir_ff == IR_CFG_LOAD) begin
                nxt_tdo = dr_ff[0];
            end else begin
                nxt_tdo = byp_ff;
            end
        end
    end

    // TAP registers
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            tap_ff <= TS_RESET;
            ir_ff <= IR_BYPASS;
            irs_ff <= IR_BYPASS;
            dr_ff <= '0;
            bcnt_ff <= 5'h00;
            byp_ff <= 1'b0;
            tdo_ff <= 1'b0;
        end else begin
            tap_ff <= nxt_tap;
            ir_ff <= nxt_ir;
            irs_ff <= nxt_irs;
            dr_ff <= nxt_dr;
            bcnt_ff <= nxt_bcnt;
            byp_ff <= nxt_byp;
            tdo_ff <= nxt_tdo;
        end
    end
    assign tdo = tdo_ff;
    // Start-up clocking through shift with start-up instruction
    assign tap_step = tck_rise && tap_ff == TS_SH_DR && ir_ff == IR_STARTUP;

    ////////////////////////////////////////////////////////////////////////
    // Two-entry word buffer between shifter and memory
    logic [DAT_W-1:0] buf_mem [BUF_DEPTH];
    logic wp_ff, nxt_wp, rp_ff, nxt_rp;
    logic [1:0] cnt_ff, nxt_cnt;
    logic in_ready, out_valid, out_ready, do_push, do_pop;
    cfsq_phase_e ph_ff, nxt_ph;
    logic [6:0] wa_ff, nxt_wa; // Words stored in memory
    logic restart;

    assign in_ready = (cnt_ff != 2'h2);
    assign out_valid = (cnt_ff != 2'h0);
    // Drain only while loading and memory has room
    assign out_ready = (ph_ff == PH_LOAD) && (wa_ff != 7'(MEM_DEPTH));
    assign do_push = push & in_ready;
    assign do_pop = out_valid & out_ready;

    // Buffer pointers and fill
    always_comb begin
        nxt_wp = wp_ff ^ do_push;
        nxt_rp = rp_ff ^ do_pop;
        nxt_cnt = 2'(cnt_ff + {1'b0, do_push} - {1'b0, do_pop});
        nxt_wa = do_pop ? 7'(wa_ff + 7'h01) : wa_ff;
        if (restart) begin
            nxt_wp = 1'b0;
            nxt_rp = 1'b0;
            nxt_cnt = 2'h0;
            nxt_wa = 7'h00;
        end
    end

    // Buffer registers
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            wp_ff <= 1'b0;
            rp_ff <= 1'b0;
            cnt_ff <= 2'h0;
            wa_ff <= 7'h00;
        end else begin
            wp_ff <= nxt_wp;
            rp_ff <= nxt_rp;
            cnt_ff <= nxt_cnt;
            wa_ff <= nxt_wa;
        end
    end
    // Buffer storage
    always_ff @(posedge mclk) begin
        if (do_push) begin
            buf_mem[wp_ff] <= nxt_dr;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Configuration memory: cleared in erase, filled in load
    logic [DAT_W-1:0] cfg_mem [MEM_DEPTH];
    logic [MEM_AW-1:0] ers_ff, nxt_ers; // Erase index
    logic mem_we;
    logic [MEM_AW-1:0] mem_addr;
    logic [DAT_W-1:0] mem_wdata;

    // Memory write select
    always_comb begin
        mem_we = 1'b0;
        mem_addr = wa_ff[MEM_AW-1:0];
        mem_wdata = buf_mem[rp_ff];
        if (ph_ff == PH_ERASE) begin
            mem_we = 1'b1;
            mem_addr = ers_ff;
            mem_wdata = '0;
        end else if (do_pop) begin
            mem_we = 1'b1;
        end
    end
    // Memory array
    always_ff @(posedge mclk) begin
        if (mem_we) begin
            cfg_mem[mem_addr] <= mem_wdata;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Config clock divider: tick on each rising config clock edge
    logic [7:0] cdiv_ff, nxt_cdiv;
    logic cfgclk_ff, nxt_cfgclk, cfg_tick;
    always_comb begin
        cfg_tick = 1'b0;
        nxt_cfgclk = cfgclk_ff;
        nxt_cdiv = 8'(cdiv_ff + 8'h01);
        if (cdiv_ff == 8'(CFG_HALF_CYC - 1)) begin
            nxt_cdiv = 8'h00;
            nxt_cfgclk = ~cfgclk_ff;
            cfg_tick = ~cfgclk_ff;
        end
    end
    // Divider registers
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            cdiv_ff <= 8'h00;
            cfgclk_ff <= 1'b0;
        end else begin
            cdiv_ff <= nxt_cdiv;
            cfgclk_ff <= nxt_cfgclk;
        end
    end
    assign config_clock = cfgclk_ff;

    ////////////////////////////////////////////////////////////////////////
    // Phase sequencer and global controls
    logic done_ff, otri_ff, finit_ff, wren_ff, oe_ff;
    logic nxt_done, nxt_otri, nxt_finit, nxt_wren, nxt_oe;
    logic tap_mode, step, sw_restart;
    logic [6:0] ctrl_ff, nxt_ctrl; // {readback index, clock select}

    assign tap_mode = (pins.mode == MODE_TAP_A) || (pins.mode == MODE_TAP_B);
    // Start-up steps on TCK in test-port mode unless software picks the config clock
    assign step = (tap_mode && !ctrl_ff[0]) ? tap_step : cfg_tick;
    assign restart = !pins.restart_n || sw_restart;

    // Next phase and outputs
    always_comb begin
        nxt_ph = ph_ff;
        nxt_ers = ers_ff;
        if (restart) begin
            nxt_ph = PH_ERASE;
            nxt_ers = '0;
        end else begin
            case (ph_ff)
                PH_ERASE: begin
                    nxt_ers = MEM_AW'(ers_ff + 1'b1);
                    if (ers_ff == MEM_AW'(MEM_DEPTH - 1)) begin
                        nxt_ph = PH_HOLD;
                    end
                end
                PH_HOLD: if (pins.init) begin
                    nxt_ph = PH_LOAD;
                end
                PH_LOAD: if (tap_step) begin
                    nxt_ph = PH_SU_DONE;
                end
                PH_SU_DONE: if (step) begin
                    nxt_ph = PH_SU_TRI;
                end
                PH_SU_TRI: if (step) begin
                    nxt_ph = PH_RUN;
                end
                PH_RUN: ;
                default: nxt_ph = PH_ERASE;
            endcase
        end
        nxt_oe = (nxt_ph == PH_ERASE);
        nxt_done = (nxt_ph == PH_SU_DONE) || (nxt_ph == PH_SU_TRI) || (nxt_ph == PH_RUN);
        nxt_otri = !nxt_done || (nxt_ph == PH_SU_DONE);
        nxt_finit = (nxt_ph != PH_RUN);
        nxt_wren = (nxt_ph == PH_RUN);
    end

    // Phase registers; erase starts straight from reset
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            ph_ff <= PH_ERASE;
            ers_ff <= '0;
            oe_ff <= 1'b1;
            done_ff <= 1'b0;
            otri_ff <= 1'b1;
            finit_ff <= 1'b1;
            wren_ff <= 1'b0;
        end else begin
            ph_ff <= nxt_ph;
            ers_ff <= nxt_ers;
            oe_ff <= nxt_oe;
            done_ff <= nxt_done;
            otri_ff <= nxt_otri;
            finit_ff <= nxt_finit;
            wren_ff <= nxt_wren;
        end
    end
    assign mem_clear_out = 1'b0; // Open drain: only ever pulls low
    assign mem_clear_oe = oe_ff;
    assign config_done = done_ff;
    assign global_output_tristate = otri_ff;
    assign global_flop_init = finit_ff;
    assign global_storage_write_enable = wren_ff;

    ////////////////////////////////////////////////////////////////////////
    // Avalon-MM slave: one wait cycle, then answer
    logic ack_ff, nxt_ack, ovf_ff, nxt_ovf, bus_done;
    logic [31:0] rdata_ff, nxt_rdata;
    cfsq_status_s stat;

    // Address match
    function automatic logic hit(input logic [3:0] a, input logic [3:0] off);
        hit = (a == off);
    endfunction : hit

    assign stat = '{zero: '0, wren: wren_ff, finit: finit_ff, otri: otri_ff, ovf: ovf_ff,
                    mode: pins.mode, tap_mode: tap_mode, init_lvl: pins.init,
                    done: done_ff, phase: ph_ff};
    assign bus_done = (avs_read | avs_write) & ack_ff;
    assign avs_waitrequest = (avs_read | avs_write) & ~ack_ff;
    assign sw_restart = bus_done && avs_write && hit(avs_address, REG_CTRL) && avs_writedata[CTRL_RESTART_BIT];

    // Next bus state, control and sticky overflow
    always_comb begin
        nxt_ack = (avs_read | avs_write) & ~ack_ff;
        nxt_rdata = rdata_ff;
        nxt_ctrl = ctrl_ff;
        if (avs_read && !ack_ff) begin
            if (hit(avs_address, REG_CTRL)) begin
                nxt_rdata = {18'h0, ctrl_ff[6:1], 6'h00, ctrl_ff[0], 1'b0}; // Clock select back at bit 1
            end else if (hit(avs_address, REG_STATUS)) begin
                nxt_rdata = stat;
            end else if (hit(avs_address, REG_WORDS)) begin
                nxt_rdata = {25'h0000000, wa_ff};
            end else if (hit(avs_address, REG_MEM)) begin
                nxt_rdata = cfg_mem[ctrl_ff[6:1]];
            end else begin
                nxt_rdata = 32'h00000000; // Unmapped reads zero
            end
        end
        if (bus_done && avs_write && hit(avs_address, REG_CTRL)) begin
            nxt_ctrl = {avs_writedata[CTRL_IDX_LSB +: MEM_AW], avs_writedata[CTRL_CFGCLK_SEL_BIT]};
        end
        // Lost word sets; set wins over write-one clear
        nxt_ovf = (push & ~in_ready) | (ovf_ff & ~(bus_done && avs_write &&
                  hit(avs_address, REG_STATUS) && avs_writedata[STAT_OVF_BIT]));
    end

    // Bus registers
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            ack_ff <= 1'b0;
            rdata_ff <= 32'h00000000;
            ctrl_ff <= CTRL_RESET;
            ovf_ff <= 1'b0;
        end else begin
            ack_ff <= nxt_ack;
            rdata_ff <= nxt_rdata;
            ctrl_ff <= nxt_ctrl;
            ovf_ff <= nxt_ovf;
        end
    end
    assign avs_readdata = rdata_ff;

    ////////////////////////////////////////////////////////////////////////
    // Checks
    property p_erase_drive;
        @(posedge mclk) disable iff (!resetn) (ph_ff == PH_ERASE) |-> mem_clear_oe;
    endproperty
    a_erase_drive: assert property (p_erase_drive) else $error("clear pin not driven in erase");
    property p_erase_end;
        @(posedge mclk) disable iff (!resetn) (ph_ff == PH_ERASE && nxt_ph == PH_HOLD) |=> !mem_clear_oe;
    endproperty
    a_erase_end: assert property (p_erase_end) else $error("clear pin held after erase");
    property p_hold_wait;
        @(posedge mclk) disable iff (!resetn) (ph_ff == PH_HOLD && !pins.init) |=> ph_ff != PH_LOAD;
    endproperty
    a_hold_wait: assert property (p_hold_wait) else $error("load began with clear pin low");
    property p_restart;
        @(posedge mclk) disable iff (!resetn) !pins.restart_n |=> (ph_ff == PH_ERASE && ers_ff == '0);
    endproperty
    a_restart: assert property (p_restart) else $error("restart did not erase");
    property p_tri_rel;
        @(posedge mclk) disable iff (!resetn) (ph_ff == PH_SU_DONE && step && !restart) |=>
            (!otri_ff && finit_ff && done_ff);
    endproperty
    a_tri_rel: assert property (p_tri_rel) else $error("tristate release wrong");
    property p_finit_rel;
        @(posedge mclk) disable iff (!resetn) (ph_ff == PH_SU_TRI && step && !restart) |=>
            (!finit_ff && wren_ff && !otri_ff);
    endproperty
    a_finit_rel: assert property (p_finit_rel) else $error("init/write release wrong");
    property p_hold_init;
        @(posedge mclk) disable iff (!resetn) otri_ff |-> (finit_ff && !wren_ff);
    endproperty
    a_hold_init: assert property (p_hold_init) else $error("flops freed too early");
    property p_done;
        @(posedge mclk) disable iff (!resetn) $rose(done_ff) |-> (otri_ff && $past(ph_ff) == PH_LOAD);
    endproperty
    a_done: assert property (p_done) else $error("done rose out of order");
    property p_pack;
        @(posedge mclk) disable iff (!resetn) (push && in_ready && !restart) |=> (cnt_ff != 2'h0);
    endproperty
    a_pack: assert property (p_pack) else $error("word not buffered");
    property p_bus;
        @(posedge mclk) disable iff (!resetn) (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest;
    endproperty
    a_bus: assert property (p_bus) else $error("bus wait too long");
endmodule : cfsq_top
`default_nettype wire

// ### tb/cfsq_tap_host.sv
// Test-port host model: walks the port states and can hold the clear wire
// Assumes mclk from the bench; test clock stands low outside steps
`timescale 1ns/1ps
`default_nettype none
module cfsq_tap_host (
    input wire logic mclk,
    output logic tck,
    output logic tms,
    output logic tdi,
    output logic hold_low
);
    import cfsq_pkg::*;
    // Idle levels; clear wire held from power-up to delay loading
    initial begin
        tck = 1'b0;
        tms = 1'b1;
        tdi = 1'b0;
        hold_low = 1'b1;
    end
    ////////////////////////////////////////////////////////////////
    // Open-drain hold of the clear wire, changed after an edge
    task automatic hold_clear(input logic h);
        @(posedge mclk);
        hold_low <= h;
    endtask : hold_clear
    // One test-clock period of 9 mclk; data line flips once its hold is over
    task automatic step(input logic m, input logic d);
        @(posedge mclk);
        tms <= m;
        tdi <= d;
        repeat (4) @(posedge mclk);
        tck <= 1'b1;
        repeat (4) @(posedge mclk);
        tck <= 1'b0;
        tdi <= ~d;
    endtask : step
    // Five high steps reset the port, one low step idles
    task automatic tap_reset();
        repeat (5) step(1'b1, 1'b0);
        step(1'b0, 1'b0);
    endtask : tap_reset
    // Idle to shift-IR, five bits LSB first, update, idle
    task automatic ir(input logic [4:0] code);
        for (int i = 0; i < 4; i++) step(i < 2, 1'b0);
        for (int i = 0; i < 5; i++) step(i == 4, code[i]);
        step(1'b1, 1'b0);
        step(1'b0, 1'b0);
    endtask : ir
    // Idle to shift-DR
    task automatic dr_enter();
        for (int i = 0; i < 3; i++) step(i == 0, 1'b0);
    endtask : dr_enter
    // One word, bit0 first; the last word leaves shift on its final bit
    task automatic dr_word(input logic [31:0] w, input logic last);
        for (int i = 0; i < 32; i++) step(last && i == 31, w[i]);
    endtask : dr_word
    // Exit through update back to idle
    task automatic dr_exit();
        step(1'b1, 1'b0);
        step(1'b0, 1'b0);
    endtask : dr_exit
endmodule : cfsq_tap_host
`default_nettype wire

// ### tb/tb_top.sv
// Bench for the sequencer: bus tasks, host model, clear wire pull-up
// Assumes 40 MHz mclk and the registers of cfsq_pkg
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    import cfsq_pkg::*;
    logic mclk, resetn, avs_read, avs_write, avs_waitrequest, restart_req_n;
    logic [3:0] avs_address;
    logic [31:0] avs_writedata, avs_readdata, rd;
    logic tck, tms, tdi, hold_low, mem_clear_out, mem_clear_oe, clear_wire;
    logic config_done, otri, gfi, wren, tdo, cfg_clk;
    logic [2:0] mode;
    int n_fail, check_count;
    // Open-drain wire with pull-up
    assign clear_wire = !((mem_clear_oe && !mem_clear_out) || hold_low);
    cfsq_top dut_u (.mclk(mclk), .resetn(resetn), .avs_address(avs_address), .avs_read(avs_read),
        .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .tck(tck), .tms(tms), .tdi(tdi), .tdo(tdo),
        .mode_select_pins(mode), .restart_req_n(restart_req_n), .mem_clear_in(clear_wire),
        .mem_clear_out(mem_clear_out), .mem_clear_oe(mem_clear_oe), .config_done(config_done),
        .config_clock(cfg_clk), .global_output_tristate(otri), .global_flop_init(gfi),
        .global_storage_write_enable(wren));
    cfsq_tap_host host_u (.mclk(mclk), .tck(tck), .tms(tms), .tdi(tdi), .hold_low(hold_low));
    ////////////////////////////////////////////////////////////////
    // Compare and count
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            n_fail++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    // One Avalon transfer, held until waitrequest is seen low
    task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d);
        @(posedge mclk);
        avs_read <= !wr;
        avs_write <= wr;
        avs_address <= a;
        avs_writedata <= d;
        @(posedge mclk);
        while (avs_waitrequest !== 1'b0) @(posedge mclk);
        rd = avs_readdata;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
    endtask : bus
    // Phase field of the status word
    task automatic stat(input logic [2:0] ph);
        bus(1'b0, REG_STATUS, 32'h0);
        chk(rd[2:0], ph);
    endtask : stat
    // One start-up step, then done, tristate, init, write enable
    task automatic su(input logic m, input logic [3:0] exp);
        host_u.step(m, 1'b0);
        repeat (4) @(posedge mclk);
        chk({config_done, otri, gfi, wren}, exp);
    endtask : su
    // Counts, verdict, end of run
    task automatic give_verdict();
        $display("checks %0d mismatches %0d", check_count, n_fail);
        if (n_fail == 0 && check_count > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask : give_verdict
    ////////////////////////////////////////////////////////////////
    // Clock
    initial begin
        mclk = 1'b0;
        forever #12.5 mclk = ~mclk;
    end
    // Hang guard, far beyond the expected run
    initial begin
        repeat (20000) @(posedge mclk);
        n_fail++;
        give_verdict();
    end
    // Main sequence
    initial begin
        resetn = 1'b0;
        avs_read = 1'b0;
        avs_write = 1'b0;
        avs_address = 4'h0;
        avs_writedata = 32'h0;
        restart_req_n = 1'b1;
        mode = 3'h5;
        repeat (20) @(posedge mclk);
        resetn <= 1'b1;
        repeat (2) @(posedge mclk);
        chk(mem_clear_oe, 1'b1);
        stat(3'h0);
        repeat (100) @(posedge mclk);
        stat(3'h1);
        host_u.hold_clear(1'b0);
        repeat (10) @(posedge mclk);
        chk(clear_wire, 1'b1);
        stat(3'h2);
        // Every mode pattern, test-port flag only for two of them
        for (int m = 0; m < 8; m++) begin
            mode <= m[2:0];
            repeat (8) @(posedge mclk);
            bus(1'b0, REG_STATUS, 32'h0);
            chk(rd[8:5], {m[2:0], m == 5 || m == 1});
        end
        bus(1'b0, 4'h2, 32'h0);
        chk(rd, 32'h0);
        // Load two words with a non-test-port mode on the pins
        host_u.tap_reset();
        host_u.ir(IR_CFG_LOAD);
        host_u.dr_enter();
        host_u.dr_word(32'hA5C3_0F01, 1'b0);
        repeat (8) @(posedge mclk);
        chk(tdo, 1'b1);
        host_u.dr_word(32'h1234_5678, 1'b1);
        host_u.dr_exit();
        repeat (20) @(posedge mclk);
        bus(1'b0, REG_WORDS, 32'h0);
        chk(rd, 32'h2);
        bus(1'b1, REG_CTRL, 32'h0000_0100);
        bus(1'b0, REG_MEM, 32'h0);
        chk(rd, 32'h1234_5678);
        chk({config_done, otri, gfi, wren}, 4'h6);
        mode <= 3'h5;
        host_u.ir(IR_STARTUP);
        host_u.dr_enter();
        su(1'b0, 4'hE);
        su(1'b0, 4'hA);
        su(1'b1, 4'h9);
        host_u.dr_exit();
        stat(3'h5);
        // Restart by pin, then by register
        restart_req_n <= 1'b0;
        repeat (10) @(posedge mclk);
        chk({mem_clear_oe, config_done, otri, gfi, wren}, 5'h16);
        restart_req_n <= 1'b1;
        repeat (100) @(posedge mclk);
        stat(3'h2);
        bus(1'b1, REG_CTRL, 32'h1);
        repeat (4) @(posedge mclk);
        chk(mem_clear_oe, 1'b1);
        // Start-up paced by the config clock once software picks it
        repeat (100) @(posedge mclk);
        stat(3'h2);
        bus(1'b1, REG_CTRL, 32'h2);
        bus(1'b0, REG_CTRL, 32'h0);
        chk(rd, 32'h2);
        rd[0] = cfg_clk;
        repeat (20) @(posedge mclk);
        chk(cfg_clk, !rd[0]);
        host_u.dr_enter();
        host_u.step(1'b1, 1'b0);
        repeat (100) @(posedge mclk);
        chk({config_done, otri, gfi, wren}, 4'h9);
        host_u.dr_exit();
        stat(3'h5);
        give_verdict();
    end
endmodule : tb_top
`default_nettype wire
